// [design/opll_pixel_pll.v]
// pixel clock digital pll with loop constant registers and line timing
//
// What this block does
// - lock register resets 0x01, hold/prop/flag/integ
// - capture register resets 0x24, gate/prop/integ
// - initial period preloads pll pixel period
// - lock after 4 quiet lines below threshold
// - large phase error returns to capture
// - each line computes new division from constants
// - ratio is 12 times (2 len plus 1)
// - left margin is (delay minus 6)*6 plus 54
// - margin floors 54 even, 60 odd
// - high frequency clock drives pll division
// - divide by three enable for timing analysis
// - gains scale by 2^(A-11), 2^(B-19)
// - line length resets 0x20, six-bit field
`timescale 1ns/1ps
`include "opll_regs.vh"
module opll_pixel_pll #(
  parameter PER_W = 24,
  parameter FRAC_W = 16,
  parameter ERR_THRESH = 8
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_wr,
  input wire i_rd,
  input wire [`OPLL_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_hsync,
  input wire i_rgb_en,
  input wire i_fast_blank,
  output reg [7:0] o_rdata,
  output reg o_pix_en,
  output reg o_vta_en,
  output reg o_rgb_en,
  output reg o_fast_blank_out,
  output reg o_lock_flag,
  output reg [11:0] o_left_margin,
  output reg [11:0] o_pix_per_line
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] lock_ff;
  reg [7:0] capt_ff;
  reg [7:0] pp_ff;
  reg [5:0] line_length_field_ff;
  reg [7:0] left_margin_delay_ff;
  reg pp_load_ff;
  // the reset value is eight bits wide; only the six field bits are kept
  wire [7:0] rst_line = `OPLL_RST_LINE;
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      lock_ff <= {`OPLL_RST_LOCK & 8'hf7};
      capt_ff <= `OPLL_RST_CAPT;
      pp_ff <= `OPLL_RST_PP;
      line_length_field_ff <= rst_line[5:0];
      left_margin_delay_ff <= `OPLL_RST_DELAY;
      pp_load_ff <= 1'b1;
    end else begin
      pp_load_ff <= 1'b0;
      if (i_wr) begin
        case (i_addr)
          `OPLL_ADDR_LOCK: lock_ff <= i_wdata & 8'hf7;
          `OPLL_ADDR_CAPT: capt_ff <= i_wdata & 8'hf7;
          `OPLL_ADDR_PP: begin
            pp_ff <= i_wdata;
            pp_load_ff <= 1'b1;
          end
          `OPLL_ADDR_LINE: line_length_field_ff <= i_wdata[5:0];
          `OPLL_ADDR_DELAY: left_margin_delay_ff <= i_wdata;
          default: begin
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // lock state
  // ----------------------------------------
  localparam ST_CAPT = 2'b01;
  localparam ST_LOCK = 2'b10;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] quiet_ff;
  reg hs_d_ff;
  wire hs_rise = i_hsync & ~hs_d_ff;
  wire dpll_hold = lock_ff[`OPLL_BIT_HOLD];
  wire locked = (state_ff == ST_LOCK);
  // ----------------------------------------
  // nco: phase accumulator steps once per high-frequency clock
  // ----------------------------------------
  // period is in hf cycles with FRAC_W fraction bits; 320 mhz maps to i_clk here
  reg [PER_W+FRAC_W-1:0] per_ff;
  reg [PER_W+FRAC_W-1:0] acc_ff;
  reg [11:0] pix_cnt_ff;
  reg signed [PER_W+FRAC_W+1:0] err_ff;
  wire [11:0] m_ratio = `OPLL_CHAR_PIX * {5'h00, line_length_field_ff, 1'b1};
  wire [PER_W+FRAC_W-1:0] one = {{(PER_W-1){1'b0}}, 1'b1, {FRAC_W{1'b0}}};
  wire acc_wrap = (acc_ff + one) >= per_ff;
  // phase error at hsync: pixels past line end (positive means pixel clock is fast)
  wire signed [PER_W+FRAC_W+1:0] ph_err =
    $signed({{(PER_W+FRAC_W-10){1'b0}}, pix_cnt_ff}) -
    $signed({{(PER_W+FRAC_W-10){1'b0}}, m_ratio});
  wire big_err = (ph_err > ERR_THRESH) || (ph_err < -ERR_THRESH);
  wire [2:0] a_sel = locked ? lock_ff[`OPLL_PROP_HI:`OPLL_PROP_LO] :
    capt_ff[`OPLL_PROP_HI:`OPLL_PROP_LO];
  wire [2:0] b_sel = locked ? lock_ff[`OPLL_INTEG_HI:`OPLL_INTEG_LO] :
    capt_ff[`OPLL_INTEG_HI:`OPLL_INTEG_LO];
  // gains 3*len*2^(A-11), 3*len*2^(B-19) applied to error in period units (FRAC_W>=19 keeps shifts exact)
  wire signed [PER_W+FRAC_W+13:0] e3l = ph_err * $signed({1'b0, line_length_field_ff, 2'b00}) -
    ph_err * $signed({2'b00, line_length_field_ff});
  wire signed [PER_W+FRAC_W+13:0] e_sh = e3l <<< FRAC_W;
  wire signed [PER_W+FRAC_W+13:0] alpha_term = e_sh >>> (`OPLL_A_OFS - a_sel);
  wire signed [PER_W+FRAC_W+13:0] beta_term = e_sh >>> (`OPLL_B_OFS - b_sel);
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= ST_CAPT;
      quiet_ff <= 3'h0;
      // held high so a sync already high at release is not taken as a line start
      hs_d_ff <= 1'b1;
      per_ff <= {PER_W+FRAC_W{1'b0}};
      acc_ff <= {PER_W+FRAC_W{1'b0}};
      pix_cnt_ff <= 12'h000;
      err_ff <= {PER_W+FRAC_W+2{1'b0}};
    end else begin
      hs_d_ff <= i_hsync;
      state_ff <= nxt_state;
      acc_ff <= acc_wrap ? {PER_W+FRAC_W{1'b0}} : acc_ff + one;
      if (acc_wrap)
        pix_cnt_ff <= pix_cnt_ff + 12'h001;
      if (pp_load_ff) begin
        // initial period is in units of the hf/3 clock, i.e. 3 hf cycles
        per_ff <= {{(PER_W-10){1'b0}}, pp_ff, 2'b00, {FRAC_W{1'b0}}} -
          {{(PER_W-8){1'b0}}, pp_ff, {FRAC_W{1'b0}}};
      end else if (hs_rise) begin
        pix_cnt_ff <= 12'h000;
        if (big_err)
          quiet_ff <= 3'h0;
        else if (quiet_ff != `OPLL_LOCK_LINES)
          quiet_ff <= quiet_ff + 3'h1;
        if (!dpll_hold) begin
          err_ff <= ph_err;
          per_ff <= per_ff + alpha_term[PER_W+FRAC_W-1:0] + beta_term[PER_W+FRAC_W-1:0] -
            ((alpha_term[PER_W+FRAC_W-1:0]) & {PER_W+FRAC_W{1'b0}});
        end
      end
    end
  end
  always @* begin
    case (state_ff)
      ST_CAPT: nxt_state = (hs_rise && !big_err && quiet_ff == `OPLL_LOCK_LINES - 3'h1) ?
        ST_LOCK : ST_CAPT;
      ST_LOCK: nxt_state = (hs_rise && big_err) ? ST_CAPT : ST_LOCK;
      default: nxt_state = ST_CAPT;
    endcase
  end
  // ----------------------------------------
  // divide by three and outputs
  // ----------------------------------------
  reg [1:0] div3_ff;
  wire [11:0] dd_margin = ({4'h0, left_margin_delay_ff} - {4'h0, `OPLL_DELAY_OFS}) * 12'h006 +
    `OPLL_MARGIN_MIN_EVEN;
  wire even_small = !left_margin_delay_ff[0] && left_margin_delay_ff <= `OPLL_DELAY_EVEN_MAX;
  wire odd_small = left_margin_delay_ff[0] && left_margin_delay_ff <= `OPLL_DELAY_ODD_MAX;
  wire gate_ok = !capt_ff[`OPLL_BIT_GATE] || locked;
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      div3_ff <= 2'h0;
      o_vta_en <= 1'b0;
      o_pix_en <= 1'b0;
      o_rgb_en <= 1'b0;
      o_fast_blank_out <= 1'b0;
      o_lock_flag <= 1'b0;
      o_left_margin <= `OPLL_MARGIN_MIN_EVEN;
      o_pix_per_line <= 12'h000;
      o_rdata <= 8'h00;
    end else begin
      div3_ff <= (div3_ff == `OPLL_HF_DIV - 2'h1) ? 2'h0 : div3_ff + 2'h1;
      o_vta_en <= (div3_ff == `OPLL_HF_DIV - 2'h1);
      o_pix_en <= acc_wrap;
      o_rgb_en <= i_rgb_en & gate_ok;
      o_fast_blank_out <= i_fast_blank & gate_ok;
      o_lock_flag <= locked;
      o_pix_per_line <= m_ratio;
      if (even_small)
        o_left_margin <= `OPLL_MARGIN_MIN_EVEN;
      else if (odd_small)
        o_left_margin <= `OPLL_MARGIN_MIN_ODD;
      else
        o_left_margin <= dd_margin;
      if (i_rd) begin
        case (i_addr)
          `OPLL_ADDR_LOCK: o_rdata <= lock_ff | {4'h0, locked, 3'h0};
          `OPLL_ADDR_CAPT: o_rdata <= capt_ff;
          `OPLL_ADDR_PP: o_rdata <= pp_ff;
          `OPLL_ADDR_LINE: o_rdata <= {2'b00, line_length_field_ff};
          `OPLL_ADDR_DELAY: o_rdata <= left_margin_delay_ff;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // opll_pixel_pll

// [dv/opll_hsync_src.sv]
// horizontal sync source model with a programmable line period
`timescale 1ns/1ps
module opll_hsync_src (
  input wire i_clk,
  input wire [15:0] i_period,
  output reg o_hsync
);
  integer n = 0;
  initial o_hsync = 1'b0;
  // eight-cycle pulse; a period change takes effect on the line in progress
  always @(posedge i_clk) begin
    n <= (n + 1 >= i_period) ? 0 : n + 1;
    o_hsync <= n < 8;
  end
endmodule // opll_hsync_src

// [dv/opll_pixel_pll_properties.sv]
// assertion checker for the pixel pll control block
`timescale 1ns/1ps
`include "opll_regs.vh"
module opll_pixel_pll_properties (
  input wire i_clk, input wire i_resetn, input wire i_wr, input wire i_rd,
  input wire [`OPLL_ADDR_W-1:0] i_addr, input wire [7:0] i_wdata, input wire i_hsync,
  input wire i_rgb_en, input wire i_fast_blank, input wire [7:0] o_rdata,
  input wire o_pix_en, input wire o_vta_en, input wire o_rgb_en, input wire o_fast_blank_out,
  input wire o_lock_flag, input wire [11:0] o_left_margin, input wire [11:0] o_pix_per_line
);
  // ----------------------------------------
  // shadow registers and line counter
  // ----------------------------------------
  reg [1:0] up_ff;
  reg [7:0] dl_ff, cp_ff, lk_ff;
  reg [5:0] len_ff;
  reg [2:0] ln_ff;
  reg hs_ff;
  wire map = i_addr == `OPLL_ADDR_LINE || i_addr == `OPLL_ADDR_DELAY ||
    i_addr == `OPLL_ADDR_LOCK || i_addr == `OPLL_ADDR_CAPT || i_addr == `OPLL_ADDR_PP;
  always @(posedge i_clk) begin
    hs_ff <= i_hsync;
    if (!i_resetn) begin
      up_ff <= 2'h0; dl_ff <= 8'h20; cp_ff <= 8'h24; lk_ff <= 8'h01; len_ff <= 6'h20;
      ln_ff <= 3'h0;
    end else begin
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
      // lines seen since the flag was last high; saturates so it cannot wrap
      if (o_lock_flag) ln_ff <= 3'h0;
      else if (i_hsync && !hs_ff && ln_ff != 3'h7) ln_ff <= ln_ff + 3'h1;
      if (i_wr && i_addr == `OPLL_ADDR_LINE) len_ff <= i_wdata[5:0];
      if (i_wr && i_addr == `OPLL_ADDR_DELAY) dl_ff <= i_wdata;
      if (i_wr && i_addr == `OPLL_ADDR_LOCK) lk_ff <= i_wdata & 8'hf7;
      if (i_wr && i_addr == `OPLL_ADDR_CAPT) cp_ff <= i_wdata & 8'hf7;
    end
  end
  function [11:0] mg(input [7:0] d);
    mg = d <= 8'h07 ? (d[0] ? 12'h03c : 12'h036) : ({4'h0, d} - 12'h006) * 12'h006 + 12'h036;
  endfunction
  sequence s_gap;
    !o_vta_en ##1 !o_vta_en ##1 o_vta_en;
  endsequence
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ppl_value_a: assert property (up_ff == 2'h3 && $stable(len_ff) |->
    o_pix_per_line == 12'h00c * ({6'h0, len_ff} * 12'h002 + 12'h001)) else $error("ppl");
  margin_value_a: assert property (up_ff == 2'h3 && $stable(dl_ff) |->
    o_left_margin == mg(dl_ff)) else $error("margin");
  vta_period_a: assert property (o_vta_en |=> s_gap) else $error("vta");
  unmapped_zero_a: assert property (i_rd && !map |=> o_rdata == 8'h00) else $error("unm");
  capt_read_a: assert property (i_rd && i_addr == `OPLL_ADDR_CAPT |=>
    o_rdata == $past(cp_ff)) else $error("capt");
  lock_read_a: assert property (i_rd && i_addr == `OPLL_ADDR_LOCK |=>
    (o_rdata & 8'hf7) == $past(lk_ff)) else $error("lock");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("hold");
  lock_lines_a: assert property ($rose(o_lock_flag) |-> ln_ff >= 3'h4)
    else $error("lines");
  gate_pass_a: assert property (up_ff == 2'h3 && cp_ff[7] == 1'b0 && $stable(cp_ff) |->
    {o_rgb_en, o_fast_blank_out} == $past({i_rgb_en, i_fast_blank})) else $error("pass");
  gate_block_a: assert property (cp_ff[7] && $past(cp_ff[7]) && !o_lock_flag &&
    !$past(o_lock_flag) |-> !o_rgb_en && !o_fast_blank_out) else $error("block");
endmodule // opll_pixel_pll_properties
bind opll_pixel_pll opll_pixel_pll_properties u_chk (.i_clk, .i_resetn, .i_wr, .i_rd, .i_addr,
  .i_wdata, .i_hsync, .i_rgb_en, .i_fast_blank, .o_rdata, .o_pix_en, .o_vta_en, .o_rgb_en,
  .o_fast_blank_out, .o_lock_flag, .o_left_margin, .o_pix_per_line);

// [dv/tb_osd_pixel_pll_control.sv]
// self-checking bench for the pixel pll control block
`timescale 1ns/1ps
`include "opll_regs.vh"
module tb_osd_pixel_pll_control;
  reg i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_rgb_en = 0, i_fast_blank = 0;
  reg [15:0] i_addr = 0, per = 216;
  reg [7:0] i_wdata = 0;
  wire [7:0] o_rdata;
  wire [11:0] o_left_margin, o_pix_per_line;
  wire i_hsync, o_pix_en, o_vta_en, o_rgb_en, o_fast_blank_out, o_lock_flag;
  integer fails = 0, checks_done = 0, cyc = 0, seed = 32'h1a2e, k, d;
  opll_pixel_pll i_dut (.i_clk, .i_resetn, .i_wr, .i_rd, .i_addr, .i_wdata, .i_hsync,
    .i_rgb_en, .i_fast_blank, .o_rdata, .o_pix_en, .o_vta_en, .o_rgb_en, .o_fast_blank_out,
    .o_lock_flag, .o_left_margin, .o_pix_per_line);
  opll_hsync_src i_src (.i_clk, .i_period(per), .o_hsync(i_hsync));
  initial forever #2 i_clk = ~i_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [11:0] g, input [11:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        fails = fails + 1;
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      @(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= v; end
      @(posedge i_clk) i_wr <= 0;
      repeat (2) @(posedge i_clk);
      #1;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
      @(posedge i_clk) i_rd <= 0;
      #1 chk(o_rdata, e);
    end
  endtask
  always @(posedge i_clk) begin
    i_rgb_en <= $random(seed);
    i_fast_blank <= $random(seed);
    cyc <= cyc + 1;
    if (cyc == 30000) begin fails = fails + 1; final_report; end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1;
    rd(`OPLL_ADDR_LOCK, 8'h01);
    rd(`OPLL_ADDR_CAPT, 8'h24);
    rd(`OPLL_ADDR_LINE, 8'h20);
    rd(16'h4031, 8'h00);
    chk(o_pix_per_line, 12'd780);
    for (k = 0; k < 12; k = k + 1) begin
      d = k < 9 ? k : $random(seed) & 255;
      wr(`OPLL_ADDR_DELAY, d);
      chk(o_left_margin, d <= 7 ? (d % 2 ? 60 : 54) : (d - 6) * 6 + 54);
      d = $random(seed) & 8'h7f;
      wr(`OPLL_ADDR_CAPT, d);
      rd(`OPLL_ADDR_CAPT, d & 8'h77);
    end
    wr(`OPLL_ADDR_LINE, 8'h3f);
    chk(o_pix_per_line, 12 * 127);
    wr(`OPLL_ADDR_LINE, 8'h00);
    chk(o_pix_per_line, 12);
    // constants known to capture, then a period matching a 216-cycle line
    wr(`OPLL_ADDR_CAPT, 8'ha4);
    wr(`OPLL_ADDR_PP, 8'h06);
    for (k = 0; k < 8000 && o_lock_flag !== 1'b1; k = k + 1) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_lock_flag, 1);
    d = 0;
    repeat (216) begin
      @(posedge i_clk);
      #1 d = d + o_pix_en;
    end
    chk(d, 12);
    rd(`OPLL_ADDR_LOCK, 8'h09);
    per <= 400;
    for (k = 0; k < 8000 && o_lock_flag !== 1'b0; k = k + 1) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_lock_flag, 0);
    repeat (3) @(posedge i_clk);
    #1 chk({o_rgb_en, o_fast_blank_out}, 0);
    wr(`OPLL_ADDR_LOCK, 8'h89);
    rd(`OPLL_ADDR_LOCK, 8'h81);
    final_report;
  end
endmodule // tb_osd_pixel_pll_control

// [include/opll_regs.vh]
// register map, field positions and constants of the pixel pll control block
`ifndef OPLL_REGS_VH
`define OPLL_REGS_VH
`define OPLL_ADDR_W 16
`define OPLL_ADDR_LINE 16'h4030
`define OPLL_ADDR_DELAY 16'h4032
`define OPLL_ADDR_LOCK 16'h4035
`define OPLL_ADDR_CAPT 16'h4036
`define OPLL_ADDR_PP 16'h4037
`define OPLL_RST_LINE 8'h20
`define OPLL_RST_DELAY 8'h20
`define OPLL_RST_LOCK 8'h01
`define OPLL_RST_CAPT 8'h24
`define OPLL_RST_PP 8'h06
`define OPLL_BIT_HOLD 7
`define OPLL_BIT_GATE 7
`define OPLL_BIT_LOCKF 3
`define OPLL_PROP_HI 6
`define OPLL_PROP_LO 4
`define OPLL_INTEG_HI 2
`define OPLL_INTEG_LO 0
`define OPLL_LOCK_LINES 3'h4
`define OPLL_HF_DIV 2'h3
`define OPLL_CHAR_PIX 12'h00c
`define OPLL_DELAY_OFS 8'h06
`define OPLL_MARGIN_MIN_EVEN 12'h036
`define OPLL_MARGIN_MIN_ODD 12'h03c
`define OPLL_DELAY_EVEN_MAX 8'h06
`define OPLL_DELAY_ODD_MAX 8'h07
`define OPLL_A_OFS 5'h0b
`define OPLL_B_OFS 5'h13
`endif
